// ### rtl/ciow_consts.svh
// named offsets, field positions, mode codes and timing of the capture
// overflow, interrupt and wake block; definitions only
`ifndef CIOW_CONSTS_SVH
`define CIOW_CONSTS_SVH

// register offsets on the plain register port
`define CIOW_ADDR_BUF 4'h0
`define CIOW_ADDR_CON 4'h2
`define CIOW_ADDR_IRQ 4'h4
`define CIOW_ADDR_AUX 4'h6

// capture control register fields
`define CIOW_CON_MODE_LSB 0
`define CIOW_CON_MODE_MSB 2
`define CIOW_CON_BNE 3
`define CIOW_CON_OV 4
`define CIOW_CON_ICI_LSB 5
`define CIOW_CON_ICI_MSB 6
`define CIOW_CON_IDLE_STOP 13

// interrupt control register fields
`define CIOW_IRQ_FLAG 0
`define CIOW_IRQ_EN 1
`define CIOW_IRQ_PRIO_LSB 2
`define CIOW_IRQ_PRIO_MSB 4

// auxiliary register fields
`define CIOW_AUX_UART_AUTOBAUD_ENABLE 0

// capture mode codes
`define CIOW_MODE_OFF 3'h0
`define CIOW_MODE_EDGE 3'h1
`define CIOW_MODE_WAKE 3'h7

// interrupt-count field value for every-event operation
`define CIOW_ICI_EVERY 2'h0

// fifo depth and flag delay after the buffer write, in cycles
`define CIOW_FIFO_DEPTH 4
`define CIOW_IRQ_DELAY 2

`endif

// ### rtl/ciow_pkg.sv
// types shared by the capture overflow, interrupt and wake block
// assumes nothing beyond a SystemVerilog compiler
package ciow_pkg;

  // software controlled capture settings
  typedef struct packed {
    logic idle_stop;
    logic [1:0] int_count;
    logic [2:0] mode;
  } ciow_ctl_t;

  // channel interrupt flag, enable and priority
  typedef struct packed {
    logic flag;
    logic enable;
    logic [2:0] prio;
  } ciow_irq_t;

endpackage

// ### rtl/ciow_fifo.sv
// small capture fifo: pushes at the tail, pops the head
// assumes the user never pushes while full; depth is a power of two
`timescale 1ns/10ps
module ciow_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic ref_clk_i, // core clock
  input wire logic rstn_i, // synchronous reset, active low
  input wire logic clear_i, // empty the fifo
  input wire logic push_i, // write one entry
  input wire logic pop_i, // drop the head entry
  input wire logic [WIDTH-1:0] wdata_i, // entry to write
  output logic [WIDTH-1:0] head_o, // oldest entry
  output logic [CW-1:0] count_o // number of entries held
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [PW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0] count_reg, count_next;

  // pointer and count update; clear wins over everything
  always_comb begin
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (clear_i) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next = '0;
    end else begin
      if (push_i) begin
        mem_next[wr_ptr_reg] = wdata_i;
        wr_ptr_next = wr_ptr_reg + 1'b1;
      end
      if (pop_i) begin
        rd_ptr_next = rd_ptr_reg + 1'b1;
      end
      if (push_i && !pop_i) begin
        count_next = count_reg + 1'b1;
      end else if (pop_i && !push_i) begin
        count_next = count_reg - 1'b1;
      end
    end
  end

  // storage holds no reset: contents of an empty fifo are undefined
  always_ff @(posedge ref_clk_i) begin
    mem_reg <= mem_next;
    if (!rstn_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  assign head_o = mem_reg[rd_ptr_reg];
  assign count_o = count_reg;
endmodule

// ### rtl/ciow_top.sv
// capture channel overflow tracking, interrupt counting and wake logic
// assumes edge selection and prescaling sit upstream and deliver one
// capture_event_i pulse per capture; all inputs synchronous to ref_clk_i
//
// What this block does
// - full fifo plus new event sets overrun, that event raises no interrupt
// - during overrun every capture value is dropped, fifo left untouched
// - overrun flag clears on fourth buffer read, then capture resumes
// - overrun clears on mode write of zero, emptying reads, or reset
// - interrupt-count zero: interrupt on every event, reads or overrun aside
// - each fifo write is an event; interrupt after count-field plus one events
// - nonzero interrupt count: no interrupts while overrun persists
// - event counter returns to zero whenever the fifo becomes empty
// - channel offers interrupt flag, enable and three-bit priority
// - autobaud set routes uart receive line in place of capture pin
// - asleep in wake mode, a rising pin edge wakes, interrupt if allowed
// - asleep in any other mode, pin edges never wake the device
// - idle with idle-stop clear keeps full capture operation
// - idle in wake mode, rising edge wakes without a time base
// - idle with idle-stop set behaves exactly as sleep
// - wake mode with enable set wakes on a rising edge, timer or not
// - wake mode bypasses prescaled events and ignores interrupt count
// - not-empty flag set on first capture, held until all are read
// - every-edge mode interrupts on each event and never overruns
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "ciow_consts.svh"
module ciow_top #(
  parameter int TW = 16, // captured timer width
  parameter int DEPTH = `CIOW_FIFO_DEPTH // capture fifo depth
) (
  input wire logic ref_clk_i, // 100 MHz core clock
  input wire logic rstn_i, // synchronous reset, active low
  input wire logic [3:0] addr_i, // register address
  input wire logic [15:0] wdata_i, // register write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [15:0] rdata_o, // read data, cycle after rd_i
  input wire logic capture_event_i, // one capture, one cycle
  input wire logic [TW-1:0] timer_value_i, // time base to capture
  input wire logic capture_pin_i, // capture input pin level
  input wire logic uart_rx_i, // uart receive line level
  input wire logic sleep_i, // device in sleep
  input wire logic idle_i, // device in idle
  input wire logic [2:0] cpu_prio_i, // current cpu priority
  output logic capture_input_o, // selected capture input level
  output logic irq_flag_o, // channel interrupt flag
  output logic irq_enable_o, // channel interrupt enable
  output logic [2:0] irq_prio_o, // channel interrupt priority
  output logic irq_request_o, // flag, enabled, above cpu level
  output logic wake_o // one-cycle wake request
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [CW-1:0] ONE = CW'(1);

  ciow_pkg::ciow_ctl_t ctl_reg, ctl_next;
  ciow_pkg::ciow_irq_t irq_reg, irq_next;
  logic uart_autobaud_enable_reg, uart_autobaud_enable_next;
  logic ov_reg, ov_next;
  logic [1:0] ev_cnt_reg, ev_cnt_next;
  logic [`CIOW_IRQ_DELAY-1:0] irq_pipe_reg, irq_pipe_next;
  logic cap_in_reg, cap_in_next;
  logic cap_prev_reg;
  logic wake_reg, wake_next;
  logic req_reg, req_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [TW-1:0] fifo_head;
  logic [CW-1:0] fifo_count;
  logic push, pop, full, halted, mode_active, ev, rise;
  logic wr_con, mode_off_wr, wr_irq, irq_hit, wake_set;

  // fifo of captured timer values
  ciow_fifo #(.WIDTH(TW), .DEPTH(DEPTH), .CW(CW)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .clear_i(mode_off_wr),
    .push_i(push),
    .pop_i(pop),
    .wdata_i(timer_value_i),
    .head_o(fifo_head),
    .count_o(fifo_count)
  );

  // decode of strobes, power state and input edges
  always_comb begin
    wr_con = wr_i && (addr_i == `CIOW_ADDR_CON);
    wr_irq = wr_i && (addr_i == `CIOW_ADDR_IRQ);
    mode_off_wr = wr_con && (wdata_i[`CIOW_CON_MODE_MSB:`CIOW_CON_MODE_LSB]
                  == `CIOW_MODE_OFF);
    pop = rd_i && (addr_i == `CIOW_ADDR_BUF) && (fifo_count != '0);
    halted = sleep_i || (idle_i && ctl_reg.idle_stop);
    mode_active = (ctl_reg.mode != `CIOW_MODE_OFF) &&
                  (ctl_reg.mode != `CIOW_MODE_WAKE) && !halted;
    ev = capture_event_i && mode_active && !mode_off_wr;
    // a pop in the same cycle frees a slot, so that is not full
    full = (fifo_count == FULL) && !pop;
    rise = cap_in_reg && !cap_prev_reg;
  end

  // overrun, event counting and fifo push
  always_comb begin
    push = 1'b0;
    ov_next = ov_reg;
    ev_cnt_next = ev_cnt_reg;
    irq_hit = 1'b0;
    if (ev) begin
      if (ctl_reg.mode == `CIOW_MODE_EDGE) begin
        irq_hit = 1'b1;
        push = !full; // no overrun in this mode, value just dropped
      end else if (ov_reg) begin
        irq_hit = (ctl_reg.int_count == `CIOW_ICI_EVERY);
      end else if (full) begin
        ov_next = 1'b1;
      end else begin
        push = 1'b1;
        if (ctl_reg.int_count == `CIOW_ICI_EVERY) begin
          irq_hit = 1'b1;
        end else if (ev_cnt_reg == ctl_reg.int_count) begin
          irq_hit = 1'b1;
          ev_cnt_next = 2'h0;
        end else begin
          ev_cnt_next = ev_cnt_reg + 2'h1;
        end
      end
    end
    // the read that empties a full fifo is the fourth one
    if (pop && (fifo_count == ONE) && !push) begin
      ov_next = 1'b0;
      ev_cnt_next = 2'h0;
    end
    if (mode_off_wr) begin
      ov_next = 1'b0;
      ev_cnt_next = 2'h0;
    end
  end

  // interrupt flag: set two cycles after the buffer write, set wins
  always_comb begin
    irq_pipe_next = {irq_pipe_reg[`CIOW_IRQ_DELAY-2:0], irq_hit};
    // wake mode takes rising edges straight, no prescaler or count
    wake_set = (ctl_reg.mode == `CIOW_MODE_WAKE) && rise;
    irq_next = irq_reg;
    if (wr_irq) begin
      irq_next.flag = wdata_i[`CIOW_IRQ_FLAG];
      irq_next.enable = wdata_i[`CIOW_IRQ_EN];
      irq_next.prio = wdata_i[`CIOW_IRQ_PRIO_MSB:`CIOW_IRQ_PRIO_LSB];
    end
    if (irq_pipe_reg[`CIOW_IRQ_DELAY-1] || wake_set) begin
      irq_next.flag = 1'b1;
    end
    req_next = irq_next.flag && irq_next.enable &&
               (irq_next.prio > cpu_prio_i);
    // wake needs sleep or idle, the pin edge in wake mode and the enable, never a timer
    wake_next = (sleep_i || idle_i) && wake_set && irq_reg.enable;
  end

  // control registers and input selection
  always_comb begin
    ctl_next = ctl_reg;
    uart_autobaud_enable_next = uart_autobaud_enable_reg;
    if (wr_con) begin
      ctl_next.mode = wdata_i[`CIOW_CON_MODE_MSB:`CIOW_CON_MODE_LSB];
      ctl_next.int_count = wdata_i[`CIOW_CON_ICI_MSB:`CIOW_CON_ICI_LSB];
      ctl_next.idle_stop = wdata_i[`CIOW_CON_IDLE_STOP];
    end
    if (wr_i && (addr_i == `CIOW_ADDR_AUX)) begin
      uart_autobaud_enable_next = wdata_i[`CIOW_AUX_UART_AUTOBAUD_ENABLE];
    end
    cap_in_next = uart_autobaud_enable_reg ? uart_rx_i : capture_pin_i;
  end

  // read data, zero outside the cycle after a read strobe
  always_comb begin
    rdata_next = 16'h0000;
    if (rd_i) begin
      unique case (addr_i)
        `CIOW_ADDR_BUF: rdata_next[TW-1:0] = fifo_head;
        `CIOW_ADDR_CON: begin
          rdata_next[`CIOW_CON_MODE_MSB:`CIOW_CON_MODE_LSB] = ctl_reg.mode;
          rdata_next[`CIOW_CON_BNE] = (fifo_count != '0);
          rdata_next[`CIOW_CON_OV] = ov_reg;
          rdata_next[`CIOW_CON_ICI_MSB:`CIOW_CON_ICI_LSB] = ctl_reg.int_count;
          rdata_next[`CIOW_CON_IDLE_STOP] = ctl_reg.idle_stop;
        end
        `CIOW_ADDR_IRQ: begin
          rdata_next[`CIOW_IRQ_FLAG] = irq_reg.flag;
          rdata_next[`CIOW_IRQ_EN] = irq_reg.enable;
          rdata_next[`CIOW_IRQ_PRIO_MSB:`CIOW_IRQ_PRIO_LSB] = irq_reg.prio;
        end
        `CIOW_ADDR_AUX: rdata_next[`CIOW_AUX_UART_AUTOBAUD_ENABLE] = uart_autobaud_enable_reg;
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  // all state outside the fifo registered here
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ctl_reg <= '0;
      irq_reg <= '0;
      uart_autobaud_enable_reg <= 1'b0;
      ov_reg <= 1'b0;
      ev_cnt_reg <= 2'h0;
      irq_pipe_reg <= '0;
      cap_in_reg <= 1'b0;
      cap_prev_reg <= 1'b0;
      wake_reg <= 1'b0;
      req_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      ctl_reg <= ctl_next;
      irq_reg <= irq_next;
      uart_autobaud_enable_reg <= uart_autobaud_enable_next;
      ov_reg <= ov_next;
      ev_cnt_reg <= ev_cnt_next;
      irq_pipe_reg <= irq_pipe_next;
      cap_in_reg <= cap_in_next;
      cap_prev_reg <= cap_in_reg;
      wake_reg <= wake_next;
      req_reg <= req_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign capture_input_o = cap_in_reg;
  assign irq_flag_o = irq_reg.flag;
  assign irq_enable_o = irq_reg.enable;
  assign irq_prio_o = irq_reg.prio;
  assign irq_request_o = req_reg;
  assign wake_o = wake_reg;

  // checks on the logic above
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_flag_after_write;
    ##1 irq_pipe_reg[0] ##1 irq_pipe_reg[1] ##1 irq_reg.flag;
  endsequence

  sequence s_overflow_event;
    ev && ctl_reg.mode != `CIOW_MODE_EDGE && !ov_reg && full;
  endsequence

  chk_ovf_sets_flag: assert property (
    s_overflow_event |=> ov_reg ##1 ov_reg || pop)
    else $error("overrun flag not set on overflow");
  chk_ovf_no_irq: assert property (
    s_overflow_event |=> !irq_pipe_reg[0])
    else $error("overflowing event raised an interrupt");
  chk_ovf_keeps_fifo: assert property (
    ov_reg && !pop && !mode_off_wr |=> $stable(fifo_count))
    else $error("fifo changed during overrun");
  chk_ov_read_clear: assert property (
    ov_reg && pop && fifo_count == ONE |=> !ov_reg)
    else $error("overrun kept after fourth read");
  chk_mode_off_clear: assert property (
    mode_off_wr |=> !ov_reg && fifo_count == '0 && ev_cnt_reg == 2'h0)
    else $error("mode off did not clear");
  chk_every_event: assert property (
    ev && ctl_reg.int_count == `CIOW_ICI_EVERY &&
    !(ctl_reg.mode != `CIOW_MODE_EDGE && !ov_reg && full)
    |-> s_flag_after_write)
    else $error("every-event interrupt missing");
  chk_count_hit: assert property (
    ev && !ov_reg && !full && ctl_reg.int_count != `CIOW_ICI_EVERY &&
    ev_cnt_reg == ctl_reg.int_count |-> s_flag_after_write)
    else $error("interrupt not raised at count");
  chk_ovf_mask: assert property (
    ov_reg && ctl_reg.int_count != `CIOW_ICI_EVERY &&
    ctl_reg.mode != `CIOW_MODE_EDGE |=> !irq_pipe_reg[0])
    else $error("interrupt during overrun");
  chk_empty_cnt: assert property (
    fifo_count == '0 |-> ev_cnt_reg == 2'h0)
    else $error("event count not reset on empty");
  chk_autobaud_route: assert property (
    uart_autobaud_enable_reg |=> capture_input_o == $past(uart_rx_i))
    else $error("autobaud routing wrong");
  chk_wake_edge: assert property (
    sleep_i && wake_set && irq_reg.enable |=> wake_o)
    else $error("no wake on rising edge");
  chk_no_wake: assert property (
    ctl_reg.mode != `CIOW_MODE_WAKE |=> !wake_o)
    else $error("wake outside wake mode");
  chk_idle_halt: assert property (
    idle_i && ctl_reg.idle_stop && !pop && !mode_off_wr
    |=> $stable(fifo_count))
    else $error("capture ran while stopped in idle");
  chk_bne_read: assert property (
    rd_i && addr_i == `CIOW_ADDR_CON
    |=> rdata_o[`CIOW_CON_BNE] == $past(fifo_count != '0))
    else $error("not-empty flag wrong");
  chk_edge_no_ov: assert property (
    ctl_reg.mode == `CIOW_MODE_EDGE && !ov_reg |=> !ov_reg)
    else $error("overrun in every-edge mode");
  chk_idle_wake: assert property (
    idle_i && wake_set && irq_reg.enable |=> wake_o)
    else $error("no wake from idle on rising edge");
  chk_wake_flag: assert property (
    wake_set |=> irq_reg.flag)
    else $error("wake edge did not set the flag");
  chk_wake_no_push: assert property (
    ctl_reg.mode == `CIOW_MODE_WAKE |-> !push)
    else $error("capture stored in wake mode");
endmodule

// ### verif/ciow_src.sv
// model of the far side: a pulse source on the capture pin and time base
// assumes bench requests change just after a rising clock edge
`timescale 1ns/10ps
module ciow_src (
  input wire logic ref_clk_i, // core clock
  input wire logic fire_i, // one capture event per cycle held
  input wire logic [15:0] val_i, // timer value for that event
  input wire logic pin_i, // wanted pin level
  output logic event_o, // capture event pulse
  output logic [15:0] tval_o, // timer value beside the event
  output logic pin_o // capture pin level
);
  // defined levels from time zero, one process drives each level
  logic event_reg = 1'h0;
  logic [15:0] tval_reg = 16'h0;
  logic pin_reg = 1'h0;

  // value inverted outside events so a stale capture never matches
  always @(posedge ref_clk_i) begin
    event_reg <= fire_i;
    tval_reg <= fire_i ? val_i : ~tval_reg;
    pin_reg <= pin_i;
  end

  assign event_o = event_reg;
  assign tval_o = tval_reg;
  assign pin_o = pin_reg;
endmodule

// ### verif/ciow_top_test.sv
// self-checking bench for the capture overflow, interrupt and wake block
// assumes the source model in ciow_src.sv and the constants header
`timescale 1ns/10ps
`include "ciow_consts.svh"
module ciow_top_test;
  localparam logic [3:0] a_buf = `CIOW_ADDR_BUF;
  localparam logic [3:0] a_con = `CIOW_ADDR_CON;
  localparam logic [3:0] a_irq = `CIOW_ADDR_IRQ;
  localparam logic [3:0] a_aux = `CIOW_ADDR_AUX;
  logic ref_clk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0;
  logic [15:0] val = 16'h0;
  logic wr_i = 1'h0;
  logic rd_i = 1'h0;
  logic fire = 1'h0;
  logic pin = 1'h0;
  logic uart_rx_i = 1'h0;
  logic sleep_i = 1'h0;
  logic idle_i = 1'h0;
  logic rd_pend = 1'h0;
  logic [2:0] cpu_prio_i = 3'h2;
  logic [15:0] rdata_o;
  logic [15:0] tval;
  logic ev;
  logic pin_w;
  logic capture_input_o;
  logic irq_flag_o;
  logic irq_enable_o;
  logic irq_request_o;
  logic wake_o;
  logic [2:0] irq_prio_o;
  logic [15:0] exp_q[$];
  logic [15:0] vals[$];
  int errors = 0;
  int checks_done = 0;
  int wakes = 0;

  initial forever #5 ref_clk_i = ~ref_clk_i;

  ciow_src src_u (.ref_clk_i(ref_clk_i), .fire_i(fire), .val_i(val),
    .pin_i(pin), .event_o(ev), .tval_o(tval), .pin_o(pin_w));

  ciow_top dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .capture_event_i(ev), .timer_value_i(tval), .capture_pin_i(pin_w),
    .uart_rx_i(uart_rx_i), .sleep_i(sleep_i), .idle_i(idle_i),
    .cpu_prio_i(cpu_prio_i), .capture_input_o(capture_input_o),
    .irq_flag_o(irq_flag_o), .irq_enable_o(irq_enable_o),
    .irq_prio_o(irq_prio_o), .irq_request_o(irq_request_o),
    .wake_o(wake_o));

  task automatic complete_run;
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  function automatic logic [15:0] cw(input logic [2:0] m,
    input logic [1:0] n, input logic s, input logic o, input logic b);
    return {2'h0, s, 6'h0, n, o, b, m};
  endfunction

  // a gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge ref_clk_i);
    wr_i <= 1'h0;
    @(posedge ref_clk_i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    addr_i <= a;
    rd_i <= 1'h1;
    exp_q.push_back(e);
    @(posedge ref_clk_i);
    rd_i <= 1'h0;
    @(posedge ref_clk_i);
  endtask

  // events back to back, then time for the two-cycle flag delay
  task automatic fire_n(input int n);
    logic [15:0] v;
    for (int i = 0; i < n; i++) begin
      v = 16'($urandom);
      vals.push_back(v);
      fire <= 1'h1;
      val <= v;
      @(posedge ref_clk_i);
    end
    fire <= 1'h0;
    repeat (6) @(posedge ref_clk_i);
  endtask

  // flag and request seen, then flag cleared by software
  task automatic irq(input logic want);
    chk({14'h0, irq_flag_o, irq_request_o},
      {14'h0, want, want && (3'h5 > cpu_prio_i)});
    wr(a_irq, 16'h0016);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk_i) rd_pend <= rd_i;
  always @(negedge ref_clk_i) begin
    if (rd_pend) begin
      chk(rdata_o, exp_q.pop_front());
    end
  end

  always @(posedge ref_clk_i) begin
    if (wake_o === 1'h1) begin
      wakes++;
    end
  end

  // the whole run takes a few hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    errors++;
    complete_run();
  end

  initial begin
    void'($urandom(54));
    repeat (12) @(posedge ref_clk_i);
    rstn_i <= 1'h1;
    @(posedge ref_clk_i);
    rd(a_con, 16'h0);
    rd(a_aux, 16'h0);
    rd(4'h8, 16'h0);
    wr(a_irq, 16'h0016);
    rd(a_irq, 16'h0016);
    chk({12'h0, irq_enable_o, irq_prio_o}, 16'h000D);
    // each nonzero count setting: no flag after that many events, flag on the next
    for (int k = 1; k < 4; k++) begin
      wr(a_con, cw(3'h2, 2'(k), 1'h0, 1'h0, 1'h0));
      fire_n(k);
      irq(1'h0);
      fire_n(1);
      irq(1'h1);
      wr(a_con, 16'h0);
    end
    // overrun with count one, then four reads restore operation
    wr(a_con, cw(3'h2, 2'h1, 1'h0, 1'h0, 1'h0));
    vals.delete();
    fire_n(4);
    rd(a_con, cw(3'h2, 2'h1, 1'h0, 1'h0, 1'h1));
    wr(a_irq, 16'h0016);
    fire_n(2);
    irq(1'h0);
    rd(a_con, cw(3'h2, 2'h1, 1'h0, 1'h1, 1'h1));
    for (int i = 0; i < 4; i++) begin
      rd(a_buf, vals[i]);
    end
    rd(a_con, cw(3'h2, 2'h1, 1'h0, 1'h0, 1'h0));
    fire_n(2);
    irq(1'h1);
    rd(a_buf, vals[6]);
    rd(a_buf, vals[7]);
    // counter realigns when the fifo empties
    fire_n(1);
    rd(a_buf, vals[8]);
    fire_n(1);
    irq(1'h0);
    fire_n(1);
    irq(1'h1);
    // count zero keeps interrupting during overrun
    wr(a_con, cw(3'h2, 2'h0, 1'h0, 1'h0, 1'h0));
    fire_n(2);
    irq(1'h1);
    fire_n(1);
    irq(1'h0);
    fire_n(1);
    irq(1'h1);
    rd(a_con, cw(3'h2, 2'h0, 1'h0, 1'h1, 1'h1));
    wr(a_con, 16'h0);
    rd(a_con, 16'h0);
    // every-edge mode: each event flags, full fifo never overruns
    wr(a_con, cw(3'h1, 2'h3, 1'h0, 1'h0, 1'h0));
    vals.delete();
    for (int i = 0; i < 5; i++) begin
      fire_n(1);
      irq(1'h1);
    end
    rd(a_con, cw(3'h1, 2'h3, 1'h0, 1'h0, 1'h1));
    rd(a_buf, vals[0]);
    // autobaud borrows the capture input in every-edge mode
    wr(a_aux, 16'h0001);
    uart_rx_i <= 1'h1;
    repeat (4) @(posedge ref_clk_i);
    chk({15'h0, capture_input_o}, 16'h0001);
    uart_rx_i <= 1'h0;
    pin <= 1'h1;
    repeat (4) @(posedge ref_clk_i);
    chk({15'h0, capture_input_o}, 16'h0000);
    rd(a_aux, 16'h0001);
    wr(a_aux, 16'h0);
    repeat (3) @(posedge ref_clk_i);
    chk({15'h0, capture_input_o}, 16'h0001);
    pin <= 1'h0;
    wr(a_con, 16'h0);
    // idle: stop bit set behaves as sleep, clear keeps capturing
    idle_i <= 1'h1;
    wr(a_con, cw(3'h2, 2'h0, 1'h1, 1'h0, 1'h0));
    fire_n(1);
    irq(1'h0);
    rd(a_con, cw(3'h2, 2'h0, 1'h1, 1'h0, 1'h0));
    wr(a_con, cw(3'h2, 2'h0, 1'h0, 1'h0, 1'h0));
    fire_n(1);
    irq(1'h1);
    // sleep: pin edges wake only in wake mode
    idle_i <= 1'h0;
    sleep_i <= 1'h1;
    pin <= 1'h1;
    repeat (6) @(posedge ref_clk_i);
    pin <= 1'h0;
    wr(a_con, cw(3'h7, 2'h3, 1'h0, 1'h0, 1'h0));
    chk(16'(wakes), 16'h0000);
    fire_n(2);
    irq(1'h0);
    pin <= 1'h1;
    repeat (6) @(posedge ref_clk_i);
    chk(16'(wakes), 16'h0001);
    irq(1'h1);
    // idle wake with the cpu above the channel priority
    pin <= 1'h0;
    sleep_i <= 1'h0;
    idle_i <= 1'h1;
    cpu_prio_i <= 3'h6;
    repeat (4) @(posedge ref_clk_i);
    pin <= 1'h1;
    repeat (6) @(posedge ref_clk_i);
    chk(16'(wakes), 16'h0002);
    irq(1'h1);
    complete_run();
  end
endmodule
